// [src/mode_reg_decode.sv]
// mode register zero/one storage and decode of a ddr3 device
// Functional notes
// [RULE1] dll reset bit starts reset, self-clears
// [RULE2] controller waits 512 clocks before read
// [RULE3] write recovery from field: 5,6,7,8,10,12
// [RULE4] controller rounds write recovery up
// [RULE5] ppd bit zero: dll off, slow exit
// [RULE6] ppd bit one: dll runs, fast exit
// [RULE7] cas latency 5 to 14, whole cycles
// [RULE8] first read data at edge n+m
// [RULE9] mode_config_one held until rewrite or reset
// [RULE10] controller loads only when banks idle
// [RULE11] controller writes zero to reserved bits
// [RULE12] leveling limits usable termination values
// [RULE13] controller enables dll then resets it
// [RULE14] self refresh stops dll, restarts on exit
// [RULE15] dll off: no odt, latency six; the decode neither gates odt nor forces latency six when the dll is off
// [RULE16] drive impedance from two bits
// [RULE17] output disable tri-states data and strobe
// [RULE18] termination strobe replaces data mask on x8
// [RULE19] x16 keeps termination strobe disabled
// [RULE20] nominal termination from three bits
// [RULE21] controller turns odt off for reads
// [RULE22] odt pin gates termination, write substitutes
// [RULE23] burst length field, otf via a12
// [RULE24] controller waits mode update delay
`timescale 1ns/10ps
module mode_reg_decode
    import mode_reg_pkg::*;
#(
    parameter bit IS_X8 = 1'b1
) (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         ck,
    input  wire logic                         cke,
    input  wire logic                         cs_n,
    input  wire logic                         ras_n,
    input  wire logic                         cas_n,
    input  wire logic                         we_n,
    input  wire logic [mode_reg_pkg::BA_W-1:0]   ba,
    input  wire logic [mode_reg_pkg::ADDR_W-1:0] addr,
    input  wire logic                         odt,
    input  wire logic                         wr_burst,
    input  wire logic                         dyn_rtt_en,
    input  wire logic [mode_reg_pkg::DIV_W-1:0]  dyn_rtt_div,
    output logic                              dll_on,
    output logic                              dll_reset,
    output logic                              dll_locked,
    output logic [4:0]                        wr_recovery,
    output logic [3:0]                        cas_latency,
    output logic                              burst_chop,
    output logic                              rd_first_data,
    output logic                              dq_drive_en,
    output logic                              dm_en,
    output logic                              termination_strobe_term_en,
    output logic [mode_reg_pkg::DIV_W-1:0]       drive_div,
    output logic [mode_reg_pkg::DIV_W-1:0]       rtt_div,
    output logic                              slow_exit,
    output mode_reg_pkg::pwr_type                pwr_state
);
    import mode_reg_pkg::*;

    localparam int PW = 6 + ADDR_W + BA_W;
    logic [PW-1:0] pins_s;
    logic ck_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s;
    logic [BA_W-1:0]   ba_s;
    logic [ADDR_W-1:0] addr_s;

    // addr and ba are only sampled on a ck edge, well after they settle
    pin_sync #(.W(PW)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .pin  ({ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
        .q    (pins_s)
    );
    assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s} = pins_s;

    pin_sync #(.W(1)) u_odt (
        .clk  (clk),
        .nrst (nrst),
        .pin  (odt),
        .q    (odt_s)
    );

    logic [MR_W-1:0]    mr0_r, mr0_nxt, mr1_r, mr1_nxt;
    logic               ck_prev_r, cke_prev_r;
    pwr_type            pwr_r, pwr_nxt;
    logic [LOCK_W-1:0]  lock_cnt_r, lock_cnt_nxt;
    logic [RD_PIPE-1:0] rd_pipe_r, rd_pipe_nxt;
    logic               dll_on_r, dll_on_nxt, dll_reset_r, dll_reset_nxt;
    logic               dll_locked_r, dll_locked_nxt;
    logic               chop_r, chop_nxt, first_r, first_nxt;
    logic [4:0]         wr_nxt;
    logic [3:0]         cl_nxt;
    logic [DIV_W-1:0]   ods_nxt, rtt_nxt, rtt_nom;
    logic [4:0]         wr_r;
    logic [3:0]         cl_r;
    logic [DIV_W-1:0]   ods_r, rtt_r;
    logic               drive_r, dm_r, termination_strobe_r, slow_r;
    logic               tick, cmd, is_mrs, is_rd, is_wr, is_ref, start_reset, reading;
    logic               dll_en;

    always_comb begin
        tick    = ck_s && !ck_prev_r;
        cmd     = tick && cke_prev_r && !cs_s;
        is_mrs  = cmd && !ras_s && !cas_s && !we_s;
        is_ref  = tick && !cs_s && !ras_s && !cas_s && we_s;
        is_rd   = cmd && ras_s && !cas_s && we_s;
        is_wr   = cmd && ras_s && !cas_s && !we_s;
        dll_en  = !mr1_r[MR1_DLL_DIS];
        reading = |rd_pipe_r;
        mr0_nxt = mr0_r;
        mr1_nxt = mr1_r;
        pwr_nxt = pwr_r;
        start_reset = 1'b0;
        // stored reset bit only lives for the cycle after the write
        mr0_nxt[MR0_DLL_RST] = 1'b0; // RULE1
        if (is_mrs && ba_s == BA_MODE_ZERO) begin
            mr0_nxt     = addr_s;
            start_reset = addr_s[MR0_DLL_RST]; // RULE1
        end
        if (is_mrs && ba_s == BA_MODE_ONE) begin
            mr1_nxt = addr_s; // RULE9
        end
        case (pwr_r)
            PWR_ACTIVE: begin
                if (is_ref && !cke_s) begin
                    pwr_nxt = PWR_SELFREF;
                end else if (tick && cke_prev_r && !cke_s) begin
                    pwr_nxt = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (tick && cke_s) begin
                    pwr_nxt = PWR_ACTIVE;
                end
            end
            PWR_SELFREF: begin
                if (tick && cke_s) begin
                    pwr_nxt     = PWR_ACTIVE;
                    start_reset = start_reset || dll_en; // RULE14
                end
            end
            default: pwr_nxt = PWR_ACTIVE;
        endcase
        // dll stops in self refresh and, with slow exit, in power-down
        dll_on_nxt = dll_en && pwr_nxt != PWR_SELFREF // RULE14
            && !(pwr_nxt == PWR_DOWN && !mr0_nxt[MR0_PPD]); // RULE5 RULE6
        dll_reset_nxt = start_reset;
        lock_cnt_nxt  = lock_cnt_r;
        dll_locked_nxt = dll_locked_r;
        if (start_reset || !dll_on_nxt) begin
            lock_cnt_nxt   = '0;
            dll_locked_nxt = 1'b0;
        end else if (tick && !dll_locked_r) begin
            lock_cnt_nxt   = lock_cnt_r + 1'b1;
            dll_locked_nxt = lock_cnt_r == LOCK_W'(DLL_LOCK_CYCLES - 1);
        end
        case (mr0_nxt[MR0_WR_LO +: 3]) // RULE3
            3'h1:    wr_nxt = 5'h05;
            3'h2:    wr_nxt = 5'h06;
            3'h3:    wr_nxt = 5'h07;
            3'h4:    wr_nxt = 5'h08;
            3'h5:    wr_nxt = 5'h0a;
            3'h6:    wr_nxt = 5'h0c;
            default: wr_nxt = 5'h00;
        endcase
        case ({mr0_nxt[MR0_CL_LO +: 3], mr0_nxt[MR0_CL_LSB]}) // RULE7
            4'h2:    cl_nxt = 4'h5;
            4'h4:    cl_nxt = 4'h6;
            4'h6:    cl_nxt = 4'h7;
            4'h8:    cl_nxt = 4'h8;
            4'ha:    cl_nxt = 4'h9;
            4'hc:    cl_nxt = 4'ha;
            4'he:    cl_nxt = 4'hb;
            4'h1:    cl_nxt = 4'hc;
            4'h3:    cl_nxt = 4'hd;
            4'h5:    cl_nxt = 4'he;
            default: cl_nxt = 4'h0;
        endcase
        chop_nxt = chop_r;
        if (is_rd || is_wr) begin
            case (mr0_r[MR0_BL_LO +: 2]) // RULE23
                BL_OTF:   chop_nxt = !addr_s[OTF_ADDR_BIT];
                BL_CHOP4: chop_nxt = 1'b1;
                default:  chop_nxt = 1'b0;
            endcase
        end
        rd_pipe_nxt = rd_pipe_r;
        first_nxt   = 1'b0;
        if (tick) begin
            rd_pipe_nxt = {rd_pipe_r[RD_PIPE-2:0], is_rd};
            // bit m-1 before edge n+m: the read seen at edge n lands on n+m
            first_nxt   = cl_r != 4'h0 && rd_pipe_r[cl_r - 4'h1]; // RULE8
        end
        case ({mr1_nxt[MR1_ODS_HI], mr1_nxt[MR1_ODS_LO]}) // RULE16
            2'h0:    ods_nxt = 4'h6;
            2'h1:    ods_nxt = 4'h7;
            default: ods_nxt = 4'h0;
        endcase
        case ({mr1_nxt[MR1_RTT_2], mr1_nxt[MR1_RTT_1], mr1_nxt[MR1_RTT_0]}) // RULE20
            3'h1:    rtt_nom = 4'h4;
            3'h2:    rtt_nom = 4'h2;
            3'h3:    rtt_nom = 4'h6;
            3'h4:    rtt_nom = 4'hc;
            3'h5:    rtt_nom = 4'h8;
            default: rtt_nom = 4'h0;
        endcase
        // leveling without output disable keeps only /2, /4 and /6
        if (mr1_nxt[MR1_WLEVEL] && !mr1_nxt[MR1_QOFF]
                && rtt_nom != 4'h2 && rtt_nom != 4'h4 && rtt_nom != 4'h6) begin
            rtt_nom = 4'h0; // RULE12
        end
        rtt_nxt = 4'h0;
        if (odt_s && pwr_nxt != PWR_SELFREF && !reading) begin
            // dynamic termination is not offered during leveling
            if (wr_burst && dyn_rtt_en && !mr1_nxt[MR1_WLEVEL]) begin
                rtt_nxt = dyn_rtt_div; // RULE22
            end else begin
                rtt_nxt = rtt_nom; // RULE22
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mr0_r        <= MR_RESET;
            mr1_r        <= MR_RESET;
            ck_prev_r    <= 1'b0;
            cke_prev_r   <= 1'b0;
            pwr_r        <= PWR_ACTIVE;
            lock_cnt_r   <= '0;
            rd_pipe_r    <= '0;
            dll_on_r     <= 1'b0;
            dll_reset_r  <= 1'b0;
            dll_locked_r <= 1'b0;
            chop_r       <= 1'b0;
            first_r      <= 1'b0;
            wr_r         <= '0;
            cl_r         <= '0;
            ods_r        <= '0;
            rtt_r        <= '0;
            drive_r      <= 1'b1;
            dm_r         <= 1'b1;
            termination_strobe_r       <= 1'b0;
            slow_r       <= 1'b1;
        end else begin
            mr0_r        <= mr0_nxt;
            mr1_r        <= mr1_nxt;
            ck_prev_r    <= ck_s;
            if (tick) begin
                cke_prev_r <= cke_s;
            end
            pwr_r        <= pwr_nxt;
            lock_cnt_r   <= lock_cnt_nxt;
            rd_pipe_r    <= rd_pipe_nxt;
            dll_on_r     <= dll_on_nxt;
            dll_reset_r  <= dll_reset_nxt;
            dll_locked_r <= dll_locked_nxt;
            chop_r       <= chop_nxt;
            first_r      <= first_nxt;
            wr_r         <= wr_nxt;
            cl_r         <= cl_nxt;
            ods_r        <= ods_nxt;
            rtt_r        <= rtt_nxt;
            drive_r      <= !mr1_nxt[MR1_QOFF]; // RULE17
            termination_strobe_r       <= IS_X8 && mr1_nxt[MR1_TERMINATION_STROBE]; // RULE18
            dm_r         <= !(IS_X8 && mr1_nxt[MR1_TERMINATION_STROBE]); // RULE18
            slow_r       <= !mr0_nxt[MR0_PPD]; // RULE5 RULE6
        end
    end

    assign dll_on        = dll_on_r;
    assign dll_reset     = dll_reset_r;
    assign dll_locked    = dll_locked_r;
    assign wr_recovery   = wr_r;
    assign cas_latency   = cl_r;
    assign burst_chop    = chop_r;
    assign rd_first_data = first_r;
    assign dq_drive_en   = drive_r;
    assign dm_en         = dm_r;
    assign termination_strobe_term_en  = termination_strobe_r;
    assign drive_div     = ods_r;
    assign rtt_div       = rtt_r;
    assign slow_exit     = slow_r;
    assign pwr_state     = pwr_r;

    a_reset_clears: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        dll_reset_r |=> !mr0_r[MR0_DLL_RST])
        else $error("dll reset bit did not self-clear");
    a_reset_pulse: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        dll_reset_r |=> !dll_reset_r)
        else $error("dll reset longer than one cycle");
    a_wr_decode: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        mr0_r[MR0_WR_LO +: 3] == 3'h6 |-> wr_r == 5'h0c)
        else $error("write recovery decode wrong");
    a_cl_decode: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        {mr0_r[MR0_CL_LO +: 3], mr0_r[MR0_CL_LSB]} == 4'h5 |-> cl_r == 4'he)
        else $error("cas latency decode wrong");
    a_pd_dll_off: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        pwr_r == PWR_DOWN && !mr0_r[MR0_PPD] |-> !dll_on_r)
        else $error("dll running in slow power-down");
    a_pd_dll_on: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        pwr_r == PWR_DOWN && mr0_r[MR0_PPD] && dll_en && $stable(pwr_r) |-> dll_on_r)
        else $error("dll stopped in fast power-down");
    a_sr_dll_off: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        pwr_r == PWR_SELFREF |-> !dll_on_r)
        else $error("dll running in self refresh");
    a_sr_exit_rst: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        pwr_r == PWR_SELFREF && tick && cke_s && dll_en |=> dll_reset_r)
        else $error("no dll reset on self refresh exit");
    a_mr1_hold: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        !(is_mrs && ba_s == BA_MODE_ONE) |=> $stable(mr1_r))
        else $error("mode_config_one changed without write");
    a_qoff_drive: assert property (@(posedge clk) disable iff (!nrst) // RULE17
        mr1_r[MR1_QOFF] |-> !dq_drive_en)
        else $error("outputs driven with output disable set");
    a_termination_strobe_dm: assert property (@(posedge clk) disable iff (!nrst) // RULE18
        IS_X8 && mr1_r[MR1_TERMINATION_STROBE] |-> termination_strobe_r && !dm_r)
        else $error("data mask active with termination strobe");
    a_rtt_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE22
        !odt_s |=> rtt_r == 4'h0)
        else $error("termination applied with odt low");
    a_wl_rtt: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        mr1_r[MR1_WLEVEL] && !mr1_r[MR1_QOFF] |-> rtt_r != 4'hc && rtt_r != 4'h8)
        else $error("read-only termination during leveling");
    a_ods_34: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        {mr1_r[MR1_ODS_HI], mr1_r[MR1_ODS_LO]} == 2'h1 |-> ods_r == 4'h7)
        else $error("drive strength decode wrong");
    a_cl5_first: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        tick && rd_pipe_r[4] && cl_r == 4'h5 |=> first_r)
        else $error("first read data not at edge n+5");
endmodule

// [src/mode_reg_pkg.sv]
// constants for the mode-register decode block
package mode_reg_pkg;
    localparam int MR_W           = 18;
    localparam int ADDR_W         = 18;
    localparam int BA_W           = 3;
    localparam int DIV_W          = 4;
    localparam int SYNC_STAGES    = 3;
    // mode register select on the bank address
    localparam logic [2:0] BA_MODE_ZERO = 3'h0;
    localparam logic [2:0] BA_MODE_ONE  = 3'h1;
    // mode_config_zero fields
    localparam int MR0_BL_LO      = 0;
    localparam int MR0_CL_LSB     = 2;
    localparam int MR0_CL_LO      = 4;
    localparam int MR0_DLL_RST    = 8;
    localparam int MR0_WR_LO      = 9;
    localparam int MR0_PPD        = 12;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_CHOP4  = 2'h2;
    localparam int OTF_ADDR_BIT   = 12;
    // mode_config_one fields
    localparam int MR1_DLL_DIS    = 0;
    localparam int MR1_ODS_LO     = 1;
    localparam int MR1_RTT_0      = 2;
    localparam int MR1_ODS_HI     = 5;
    localparam int MR1_RTT_1      = 6;
    localparam int MR1_WLEVEL     = 7;
    localparam int MR1_RTT_2      = 9;
    localparam int MR1_TERMINATION_STROBE       = 11;
    localparam int MR1_QOFF       = 12;
    localparam logic [MR_W-1:0] MR_RESET = 18'h00000;
    // timing
    localparam int DLL_LOCK_CYCLES = 512;
    localparam int LOCK_W          = 10;
    localparam int RD_PIPE         = 14;
    typedef enum logic [1:0] {
        PWR_ACTIVE  = 2'b00,
        PWR_DOWN    = 2'b01,
        PWR_SELFREF = 2'b10
    } pwr_type;
endpackage

// [src/pin_sync.sv]
// three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// [testbench/ctrl_model.sv]
// controller-side model: command pins and the link clock of the mode register path
`timescale 1ns/10ps
module ctrl_model (
    input  wire logic        clk,
    output logic             ck,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [2:0]       ba,
    output logic [17:0]      addr
);
    initial begin
        ck = 1'b0;
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 18'h00000;
    end

    // one ck rise per call, pins held for the whole ck period of 8 clk
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [17:0] a,
                       input logic ke);
        ck = 1'b0;
        cke = ke;
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        repeat (4) @(negedge clk);
        ck = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // ck parks low between frames; released lines flip so a stale value never matches
    task automatic idle();
        ck = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = ~ba;
        addr = ~addr;
        @(negedge clk);
    endtask

    // only issued with banks idle; the read loops issue it with reads still in flight
    task automatic mrs(input logic [2:0] b, input logic [17:0] a);
        logic [17:0] m;
        m = (b == 3'h1) ? 18'h26500 : 18'h26080;
        cmd(4'h0, b, a & ~m, 1'b1);
        repeat (2) cmd(4'hf, ~b, ~a, 1'b1);
        idle();
    endtask
endmodule

// [testbench/ddr3_mode_register_decode_tb.sv]
// self-checking bench for the mode register decode block
`timescale 1ns/10ps
module ddr3_mode_register_decode_tb;
    import mode_reg_pkg::*;
    logic        clk, nrst, ck, cke, cs_n, ras_n, cas_n, we_n, odt, wr_burst, dyn_rtt_en;
    logic [2:0]  ba;
    logic [17:0] addr;
    logic [3:0]  dyn_rtt_div, cas_latency, drive_div, rtt_div;
    logic        dll_on, dll_reset, dll_locked, burst_chop, rd_first_data;
    logic        dq_drive_en, dm_en, termination_strobe_term_en, slow_exit;
    logic [4:0]  wr_recovery;
    pwr_type     pwr_state;
    int          err_count = 0;
    int          n_tests = 0;
    int          ck_cnt = 0;
    int          seed;
    int          cl;
    logic [31:0] notes[$];
    logic [4:0]  wr_tab[8] = '{5'd0, 5'd5, 5'd6, 5'd7, 5'd8, 5'd10, 5'd12, 5'd0};
    logic [3:0]  rtt_tab[8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
    logic [3:0]  chop_tab[4] = '{4'b0110, 4'b0101, 4'b1011, 4'b0000};
    logic [17:0] a;

    mode_reg_decode #(.IS_X8(1'b1)) mode_reg_decode_i (
        .clk(clk), .nrst(nrst), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .wr_burst(wr_burst),
        .dyn_rtt_en(dyn_rtt_en), .dyn_rtt_div(dyn_rtt_div), .dll_on(dll_on),
        .dll_reset(dll_reset), .dll_locked(dll_locked), .wr_recovery(wr_recovery),
        .cas_latency(cas_latency), .burst_chop(burst_chop), .rd_first_data(rd_first_data),
        .dq_drive_en(dq_drive_en), .dm_en(dm_en), .termination_strobe_term_en(termination_strobe_term_en),
        .drive_div(drive_div), .rtt_div(rtt_div), .slow_exit(slow_exit),
        .pwr_state(pwr_state));

    ctrl_model ctrl_model_i (.clk(clk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge ck) ck_cnt++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // each pulse takes the oldest note: kind in the upper half, ck rise index below
    always @(negedge clk) begin
        if (nrst === 1'b1 && (dll_reset === 1'b1 || rd_first_data === 1'b1))
            check({14'h0, dll_reset, rd_first_data, ck_cnt[15:0]},
                  (notes.size() > 0) ? notes.pop_front() : 32'h0);
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        close_out();
    end

    task automatic nops(input int n, input logic ke);
        repeat (n) ctrl_model_i.cmd(4'hf, ~ba, ~addr, ke);
        ctrl_model_i.idle();
    endtask

    task automatic rd(input logic a12, input int c);
        notes.push_back(32'h10000 | 32'(ck_cnt + 1 + c));
        ctrl_model_i.cmd(4'h5, 3'h0, 18'(a12) << OTF_ADDR_BIT, 1'b1);
    endtask

    // odt held low across the load, raised once the new value stands
    task automatic term_case(input logic [17:0] v, input logic [4:0] exp);
        odt = 1'b0;
        ctrl_model_i.mrs(BA_MODE_ONE, v);
        odt = 1'b1;
        repeat (6) @(negedge clk);
        check({rtt_div, dq_drive_en}, exp);
    endtask

    task automatic reset_vals();
        check({dm_en, dq_drive_en, slow_exit, dll_on, cas_latency, wr_recovery, rtt_div,
               pwr_state, drive_div, termination_strobe_term_en}, {4'hf, 15'h0, 4'h6, 1'b0});
    endtask

    initial begin
        seed = 32'h094059e7;
        nrst = 1'b0;
        {odt, wr_burst, dyn_rtt_en} = 3'h0;
        dyn_rtt_div = 4'h0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        reset_vals();
        nops(1, 1'b1);
        ctrl_model_i.mrs(BA_MODE_ONE, 18'h00002);
        check(drive_div, 4'h7);
        notes.push_back(32'h20000 | 32'(ck_cnt + 1));
        ctrl_model_i.mrs(BA_MODE_ZERO, 18'h00110);
        check(dll_locked, 1'b0);
        nops(512, 1'b1);
        check(dll_locked, 1'b1);
        // every latency code, with write recovery and exit policy riding along
        for (int i = 0; i < 10; i++) begin
            cl = i + 5;
            a = (18'(i % 8) << MR0_WR_LO) | (18'(i % 2) << MR0_PPD);
            a = a | ((i < 7) ? 18'(i + 1) << MR0_CL_LO : (18'(i - 7) << MR0_CL_LO) | 18'h4);
            ctrl_model_i.mrs(BA_MODE_ZERO, a);
            check({cas_latency, wr_recovery, slow_exit},
                  {4'(cl), wr_tab[i % 8], 1'(~i[0])});
            rd(1'b1, cl);
            nops(cl, 1'b1);
        end
        // back-to-back reads in each burst mode
        for (int j = 0; j < 4; j++) begin
            ctrl_model_i.mrs(BA_MODE_ZERO, 18'h10 | 18'(chop_tab[j][3:2]));
            rd(chop_tab[j][1], 5);
            rd(chop_tab[j][0], 5);
            nops(5, 1'b1);
            check(burst_chop, (chop_tab[j][3:2] == BL_CHOP4) ||
                  (chop_tab[j][3:2] == BL_OTF && !chop_tab[j][0]));
        end
        // termination stays off while a read is in flight: let the last one drain
        nops(9, 1'b1);
        for (int c = 0; c < 8; c++)
            term_case(18'h2 | 18'(c % 2) << 2 | 18'((c / 2) % 2) << 6 | 18'(c / 4) << 9,
                      {rtt_tab[c], 1'b1});
        dyn_rtt_div = 4'($random(seed));
        {wr_burst, dyn_rtt_en} = 2'h3;
        term_case(18'h202, {dyn_rtt_div, 1'b1});
        term_case(18'h282, 5'h01);
        term_case(18'h1282, 5'h18);
        {odt, wr_burst} = 2'h0;
        ctrl_model_i.mrs(BA_MODE_ONE, 18'h00800);
        check({termination_strobe_term_en, dm_en, drive_div, dq_drive_en}, 7'h4d);
        ctrl_model_i.mrs(BA_MODE_ZERO, 18'h00010);
        check({termination_strobe_term_en, dm_en, drive_div, dq_drive_en}, 7'h4d);
        ctrl_model_i.mrs(BA_MODE_ONE, 18'h00003);
        ctrl_model_i.mrs(BA_MODE_ZERO, 18'h00020);
        check({dll_on, termination_strobe_term_en, dm_en}, 3'h1);
        // self refresh entered with the dll stopped: it stays stopped
        ctrl_model_i.cmd(4'h1, 3'h0, 18'h0, 1'b0);
        nops(2, 1'b0);
        check(pwr_state, PWR_SELFREF);
        nops(1, 1'b1);
        check({pwr_state, dll_on}, {PWR_ACTIVE, 1'b0});
        ctrl_model_i.mrs(BA_MODE_ONE, 18'h00002);
        notes.push_back(32'h20000 | 32'(ck_cnt + 1));
        ctrl_model_i.mrs(BA_MODE_ZERO, 18'h00110);
        check(dll_on, 1'b1);
        ctrl_model_i.cmd(4'h1, 3'h0, 18'h0, 1'b0);
        nops(2, 1'b0);
        check({pwr_state, dll_on}, {PWR_SELFREF, 1'b0});
        notes.push_back(32'h20000 | 32'(ck_cnt + 1));
        nops(1, 1'b1);
        check({pwr_state, dll_on}, {PWR_ACTIVE, 1'b1});
        for (int p = 0; p < 2; p++) begin
            ctrl_model_i.mrs(BA_MODE_ZERO, 18'h10 | 18'(p) << MR0_PPD);
            nops(2, 1'b0);
            check({pwr_state, dll_on, slow_exit}, {PWR_DOWN, 1'(p), 1'(1 - p)});
            nops(1, 1'b1);
            check({pwr_state, dll_on}, {PWR_ACTIVE, 1'b1});
        end
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        reset_vals();
        repeat (20) @(negedge clk);
        check(notes.size(), 0);
        close_out();
    end
endmodule
